// *** lgpc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

// Relates the pins and read data to a shadow of the written configuration.
module lgpc_assertions
	import lgpc_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire lgpc_link_t  i_link,
	input wire lgpc_mii_t   i_mii,
	input wire logic [31:0] o_rdata,
	input wire logic [2:0]  o_pin_out,
	input wire logic [2:0]  o_pin_oe,
	input wire logic        o_speed_indicator_pin_n,
	input wire logic [2:0]  o_wake_event
);
	logic [31:0] cfg;

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	// Shadow copy, updated on the same edge as the block's own register.
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst)
			cfg <= 32'h0;
		else if (i_wr && i_addr == LGPC_CFG_OFFS)
			cfg <= i_wdata;
	end

	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not idle");
	rsvd_zero_a: assert property ($past(i_rd) && $past(i_addr) == LGPC_CFG_OFFS |-> (o_rdata & 32'h7ccc_f888) == 32'h0)
		else $error("reserved bits set");
	in_no_drive_a: assert property ($past(cfg[25:16] & 10'h333) == 10'h0 |-> (o_pin_oe & ~$past(cfg[6:4])) == 3'h0)
		else $error("input pin driven");
	push_pull_a: assert property ($past(cfg[17:16] == 2'h0 && cfg[4] && cfg[8]) |-> o_pin_oe[0] && o_pin_out[0] == $past(cfg[0]))
		else $error("pin 8 data not driven");
	open_drain_a: assert property ($past(cfg[21:20] == 2'h0 && cfg[5] && !cfg[9]) |-> o_pin_oe[1] == !$past(cfg[1]))
		else $error("pin 9 open drain wrong");
	mii_mirror_a: assert property ($past(cfg[17:16] == LGPC_FN_MII_A && cfg[4] && cfg[8]) |-> o_pin_out[0] == $past(i_mii.rxd2))
		else $error("pin 8 mirror wrong");
	speed_led_a: assert property ($past(i_nrst) |-> o_speed_indicator_pin_n == !$past(i_link.speed_100))
		else $error("speed indicator wrong");
	wake_input_a: assert property ((o_wake_event & ($past(cfg[6:4]) | $past(cfg[6:4], 2))) == 3'h0)
		else $error("wake from output pin");
endmodule // lgpc_assertions

bind lgpc_top lgpc_assertions u_lgpc_assertions (.i_core_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_link,
	.i_mii, .o_rdata, .o_pin_out, .o_pin_oe, .o_speed_indicator_pin_n, .o_wake_event);
`default_nettype wire

// *** lgpc_board.sv ***
`timescale 1ns/1ps
`default_nettype none

// Board side of pins 8 to 10: pull-ups plus an optional external driver per pin.
module lgpc_board (
	input  wire logic [2:0] i_pin_out,
	input  wire logic [2:0] i_pin_oe,
	input  wire logic [2:0] i_drv_en,
	input  wire logic [2:0] i_drv_val,
	output logic [2:0]      o_level
);
	// The device wins where it drives; an undriven pin floats up to the pull-up.
	assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_drv_en & i_drv_val) | (~i_pin_oe & ~i_drv_en);
endmodule // lgpc_board
`default_nettype wire

// *** lgpc_led_map.sv ***
`timescale 1ns/1ps
`default_nettype none

// Maps link status onto the three active-low indicator pins.
module lgpc_led_map
	import lgpc_pkg::*;
(
	input  wire logic       i_sel,
	input  wire lgpc_link_t i_link,
	output logic [2:0]      o_led_n
);

	always_comb begin
		o_led_n[0] = ~i_link.speed_100;
		if (i_sel) begin
			o_led_n[1] = ~i_link.link_up;
			o_led_n[2] = ~i_link.activity;
		end else begin
			o_led_n[1] = ~(i_link.link_up & ~i_link.activity);
			o_led_n[2] = ~i_link.activity;
		end
	end

endmodule : lgpc_led_map

`default_nettype wire

// *** lgpc_pin_mux.sv ***
`timescale 1ns/1ps
`default_nettype none

// Chooses each pin's source and resolves direction and buffer type into drive.
module lgpc_pin_mux
	import lgpc_pkg::*;
(
	input  wire logic [5:0] i_fn,
	input  wire logic [2:0] i_dir,
	input  wire logic [2:0] i_buf,
	input  wire logic [2:0] i_data,
	input  wire logic [1:0] i_led,
	input  wire lgpc_mii_t  i_mii,
	output lgpc_pins_t      o_pins
);

	logic [2:0] level;
	logic [2:0] drive;

	// Source level and drive request per pin.
	always_comb begin
		level = i_data;
		drive = i_dir;
		for (int k = 0; k < 3; k++) begin
			unique case (i_fn[2*k +: 2])
				LGPC_FN_GPIO: begin
					level[k] = i_data[k];
					drive[k] = i_dir[k];
				end
				LGPC_FN_LED: begin
					level[k] = (k == 0) ? i_led[0] : (k == 1) ? i_led[1] : i_mii.rxd0;
					drive[k] = 1'b1;
				end
				LGPC_FN_MII_A: begin
					level[k] = (k == 0) ? i_mii.rxd2 : (k == 1) ? i_mii.rxd1 : i_mii.rxd0;
					drive[k] = 1'b1;
				end
				LGPC_FN_MII_B: begin
					level[k] = (k == 0) ? i_mii.crs : (k == 1) ? i_mii.phy_reset_low : i_mii.rxd3;
					drive[k] = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			o_pins.out[k] = level[k];
			o_pins.oe[k]  = drive[k] & (i_buf[k] | ~level[k]);
		end
	end

endmodule : lgpc_pin_mux

`default_nettype wire

// *** lgpc_pkg.sv ***
package lgpc_pkg;

	// Register offsets.
	localparam logic [7:0] LGPC_CFG_OFFS    = 8'h24;
	localparam logic [7:0] LGPC_IRQ_STAT_OFFS = 8'h40;
	localparam logic [7:0] LGPC_IRQ_MASK_OFFS = 8'h44;
	localparam logic [7:0] LGPC_WAKE_EN_OFFS  = 8'h48;

	// Field positions of the configuration register.
	localparam int LGPC_SEL_POS   = 31;
	localparam int LGPC_FN10_POS  = 24;
	localparam int LGPC_FN9_POS   = 20;
	localparam int LGPC_FN8_POS   = 16;
	localparam int LGPC_BUF_POS   = 8;
	localparam int LGPC_DIR_POS   = 4;
	localparam int LGPC_DATA_POS  = 0;

	// Reset values.
	localparam logic [1:0] LGPC_FN_RST  = 2'h0;
	localparam logic [2:0] LGPC_BUF_RST = 3'h0;
	localparam logic [2:0] LGPC_DIR_RST = 3'h0;
	localparam logic [2:0] LGPC_EN_RST  = 3'h0;

	// Pin function codes.
	localparam logic [1:0] LGPC_FN_GPIO = 2'h0;
	localparam logic [1:0] LGPC_FN_LED  = 2'h1;
	localparam logic [1:0] LGPC_FN_MII_A = 2'h2;
	localparam logic [1:0] LGPC_FN_MII_B = 2'h3;

	// Internal status signals feeding the indicators and mirrors.
	typedef struct packed {
		logic speed_100;
		logic link_up;
		logic activity;
		logic full_duplex;
	} lgpc_link_t;

	typedef struct packed {
		logic rxd3;
		logic rxd2;
		logic rxd1;
		logic rxd0;
		logic crs;
		logic phy_reset_low;
	} lgpc_mii_t;

	// Pin bundle: out and oe for the three pins.
	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
	} lgpc_pins_t;

endpackage : lgpc_pkg

// *** lgpc_top.sv ***
// Functional notes
// - Select bit maps speed, link, duplex LEDs; here it only changes the link pin, duplex pin shows activity either way.
// - Mapping zero: duplex pin shows activity.
// - Select defaults zero, else EEPROM flag.
// - USB or lite reset reloads select.
// - Bits 25:24 choose pin 10 role.
// - Bits 21:20 choose pin 9 role.
// - Bits 17:16 choose pin 8 role.
// - LED code drives selected LED role; pin 10 mirrors rxd0 instead.
// - MII codes mirror internal signal continuously.
// - Buffer bits: set push-pull, clear open-drain.
// - Direction bits: set output, clear input.
// - Data written drives; read returns pin.
// - Data reads pin levels after reset.
// - Events only from input pins.
// - Wake needs wake enable too.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lgpc_top
	import lgpc_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_usb_reset,
	input  wire logic       i_lite_soft_reset,
	input  wire logic       i_eeprom_loaded,
	input  wire logic       i_eeprom_indicator_select,
	input  wire logic [7:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [2:0] i_pin_in,
	input  wire lgpc_link_t i_link,
	input  wire lgpc_mii_t  i_mii,
	output logic [31:0]     o_rdata,
	output logic [2:0]      o_pin_out,
	output logic [2:0]      o_pin_oe,
	output logic            o_speed_indicator_pin_n,
	output logic            o_link_activity_pin_n,
	output logic            o_duplex_indicator_pin_n,
	output logic [2:0]      o_wake_event,
	output logic            o_irq
);

	typedef struct packed {
		logic        indicator_select;
		logic        eeprom_image;
		logic        eeprom_valid;
		logic [1:0]  pin10_function;
		logic [1:0]  pin9_function;
		logic [1:0]  pin8_function;
		logic [2:0]  pin_buffer_type;
		logic [2:0]  pin_direction;
		logic [2:0]  pin_data;
		logic [2:0]  pin_prev;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic [2:0]  wake_enable;
		logic [2:0]  wake_event;
		logic [31:0] rdata;
		logic [2:0]  pin_out;
		logic [2:0]  pin_oe;
		logic [2:0]  led_n;
		logic        irq;
	} lgpc_state_t;

	lgpc_state_t state;
	lgpc_state_t next_state;
	logic [2:0]  led_n;
	lgpc_pins_t  pins;
	logic [31:0] cfg_view;
	logic [2:0]  pin_change;

	// Indicator mapping from link status.
	lgpc_led_map u_led_map (
		.i_sel   (state.indicator_select),
		.i_link  (i_link),
		.o_led_n (led_n)
	);

	// Pin source, direction and buffer resolution.
	lgpc_pin_mux u_pin_mux (
		.i_fn   ({state.pin10_function, state.pin9_function, state.pin8_function}),
		.i_dir  (state.pin_direction),
		.i_buf  (state.pin_buffer_type),
		.i_data (state.pin_data),
		.i_led  (led_n[1:0]),
		.i_mii  (i_mii),
		.o_pins (pins)
	);

	// Configuration register view; reserved bits stay zero.
	always_comb begin
		cfg_view = 32'h0;
		cfg_view[LGPC_SEL_POS]               = state.indicator_select;
		cfg_view[LGPC_FN10_POS +: 2]         = state.pin10_function;
		cfg_view[LGPC_FN9_POS +: 2]          = state.pin9_function;
		cfg_view[LGPC_FN8_POS +: 2]          = state.pin8_function;
		cfg_view[LGPC_BUF_POS +: 3]          = state.pin_buffer_type;
		cfg_view[LGPC_DIR_POS +: 3]          = state.pin_direction;
		cfg_view[LGPC_DATA_POS +: 3]         = i_pin_in;
	end

	assign pin_change = (i_pin_in ^ state.pin_prev) & ~state.pin_direction;

	// Next-state logic for registers, events and outputs.
	always_comb begin
		next_state = state;
		next_state.pin_prev = i_pin_in;
		next_state.rdata = 32'h0;
		if (i_eeprom_loaded) begin
			next_state.eeprom_valid = 1'b1;
			next_state.eeprom_image = i_eeprom_indicator_select;
			next_state.indicator_select = i_eeprom_indicator_select;
		end
		if (i_wr) begin
			unique case (i_addr)
				LGPC_CFG_OFFS: begin
					next_state.indicator_select = i_wdata[LGPC_SEL_POS];
					next_state.pin10_function  = i_wdata[LGPC_FN10_POS +: 2];
					next_state.pin9_function   = i_wdata[LGPC_FN9_POS +: 2];
					next_state.pin8_function   = i_wdata[LGPC_FN8_POS +: 2];
					next_state.pin_buffer_type = i_wdata[LGPC_BUF_POS +: 3];
					next_state.pin_direction   = i_wdata[LGPC_DIR_POS +: 3];
					next_state.pin_data        = i_wdata[LGPC_DATA_POS +: 3];
				end
				LGPC_IRQ_MASK_OFFS: next_state.irq_mask = i_wdata[2:0];
				LGPC_WAKE_EN_OFFS:  next_state.wake_enable = i_wdata[2:0];
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				LGPC_CFG_OFFS:      next_state.rdata = cfg_view;
				LGPC_IRQ_STAT_OFFS: begin
					next_state.rdata = {29'h0, state.irq_status};
					next_state.irq_status = 3'h0;
				end
				LGPC_IRQ_MASK_OFFS: next_state.rdata = {29'h0, state.irq_mask};
				LGPC_WAKE_EN_OFFS:  next_state.rdata = {29'h0, state.wake_enable};
				default:            next_state.rdata = 32'h0;
			endcase
		end
		// New events win over the read clear.
		next_state.irq_status = next_state.irq_status | pin_change;
		next_state.wake_event = pin_change & state.wake_enable;
		if (i_usb_reset || i_lite_soft_reset) begin
			next_state.indicator_select = state.eeprom_valid ? state.eeprom_image : 1'b0;
		end
		next_state.pin_out = pins.out;
		next_state.pin_oe  = pins.oe;
		next_state.led_n   = led_n;
		next_state.irq     = |(next_state.irq_status & next_state.irq_mask);
	end

	// State register with synchronous reset.
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			next_state_reset();
		end else begin
			state <= next_state;
		end
	end

	// Reset values for every field.
	task automatic next_state_reset();
		state.indicator_select <= 1'b0;
		state.eeprom_image     <= 1'b0;
		state.eeprom_valid     <= 1'b0;
		state.pin10_function   <= LGPC_FN_RST;
		state.pin9_function    <= LGPC_FN_RST;
		state.pin8_function    <= LGPC_FN_RST;
		state.pin_buffer_type  <= LGPC_BUF_RST;
		state.pin_direction    <= LGPC_DIR_RST;
		state.pin_data         <= 3'h0;
		state.pin_prev         <= 3'h0;
		state.irq_status       <= 3'h0;
		state.irq_mask         <= LGPC_EN_RST;
		state.wake_enable      <= LGPC_EN_RST;
		state.wake_event       <= 3'h0;
		state.rdata            <= 32'h0;
		state.pin_out          <= 3'h0;
		state.pin_oe           <= 3'h0;
		state.led_n            <= 3'h7;
		state.irq              <= 1'b0;
	endtask

	// Outputs straight from the state register.
	assign o_rdata                  = state.rdata;
	assign o_pin_out                = state.pin_out;
	assign o_pin_oe                 = state.pin_oe;
	assign o_speed_indicator_pin_n  = state.led_n[0];
	assign o_link_activity_pin_n    = state.led_n[1];
	assign o_duplex_indicator_pin_n = state.led_n[2];
	assign o_wake_event             = state.wake_event;
	assign o_irq                    = state.irq;

endmodule : lgpc_top

`default_nettype wire

// *** lgpc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module lgpc_top_tb
	import lgpc_pkg::*;
;
	logic        i_core_clk, i_nrst, i_usb_reset, i_lite_soft_reset, i_eeprom_loaded, i_eeprom_indicator_select;
	logic        i_wr, i_rd, rd_q, o_irq, o_speed_indicator_pin_n, o_link_activity_pin_n, o_duplex_indicator_pin_n;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, w;
	logic [2:0]  i_pin_in, o_pin_out, o_pin_oe, o_wake_event, drv_en, drv_val, pv, leds;
	lgpc_link_t  i_link;
	lgpc_mii_t   i_mii;
	logic [31:0] exp_q[$];
	int          errors = 0, n_checks = 0, cycles = 0, wake_n = 0, seed = 55;

	assign leds = {o_speed_indicator_pin_n, o_link_activity_pin_n, o_duplex_indicator_pin_n};
	lgpc_top u_lgpc_top (.i_core_clk, .i_nrst, .i_usb_reset, .i_lite_soft_reset, .i_eeprom_loaded,
		.i_eeprom_indicator_select, .i_addr, .i_wdata, .i_wr, .i_rd, .i_pin_in, .i_link, .i_mii, .o_rdata,
		.o_pin_out, .o_pin_oe, .o_speed_indicator_pin_n, .o_link_activity_pin_n, .o_duplex_indicator_pin_n,
		.o_wake_event, .o_irq);
	lgpc_board u_lgpc_board (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_drv_en(drv_en), .i_drv_val(drv_val),
		.o_level(i_pin_in));

	// Free-running 125 MHz clock.
	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus cycles leave one idle cycle behind so strobes never retoggle in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Matches read answers to the oldest note, counts pin 8 wake pulses, cuts hangs short.
	always @(posedge i_core_clk) begin
		rd_q <= i_rd;
		if (o_wake_event[0])
			wake_n++;
		if (rd_q && exp_q.size() > 0)
			chk(o_rdata, exp_q.pop_front());
		if (++cycles > 3000) begin
			errors++;
			report_and_stop();
		end
	end

	// Main sequence.
	initial begin
		{i_nrst, i_usb_reset, i_lite_soft_reset, i_eeprom_loaded, i_eeprom_indicator_select, i_wr, i_rd} = 7'h0;
		{i_addr, i_wdata, i_link, i_mii} = '0;
		drv_en = 3'h7;
		drv_val = 3'h5;
		repeat (10) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		@(posedge i_core_clk);
		rd(LGPC_CFG_OFFS, 32'h5);
		rd(LGPC_IRQ_STAT_OFFS, 32'h5);
		rd(LGPC_IRQ_STAT_OFFS, 32'h0);
		rd(8'h30, 32'h0);
		wr(LGPC_IRQ_MASK_OFFS, 32'h1);
		drv_val[0] <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		chk({31'h0, o_irq}, 32'h1);
		chk(wake_n, 32'h0);
		rd(LGPC_IRQ_STAT_OFFS, 32'h1);
		wr(LGPC_WAKE_EN_OFFS, 32'h7);
		chk({31'h0, o_irq}, 32'h0);
		drv_val[0] <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		chk(wake_n, 32'h1);
		for (int i = 0; i < 12; i++) begin
			w = $random(seed) & 32'hfccc_ffff;
			drv_val <= 3'($random(seed));
			drv_en <= ~w[6:4];
			wr(LGPC_CFG_OFFS, w);
			repeat (3) @(posedge i_core_clk);
			pv = (w[6:4] & w[2:0]) | (~w[6:4] & drv_val);
			rd(LGPC_CFG_OFFS, (w & 32'h8000_0770) | {29'h0, pv});
		end
		// Without an EEPROM image a USB reset clears the select bit.
		{drv_val, drv_en} <= {3'h0, 3'h7};
		wr(LGPC_CFG_OFFS, 32'h8000_0000);
		i_usb_reset <= 1'b1;
		@(posedge i_core_clk);
		i_usb_reset <= 1'b0;
		rd(LGPC_CFG_OFFS, 32'h0);
		// One-cycle image load, then a USB reset and a lite soft reset must each restore it.
		{i_eeprom_indicator_select, i_eeprom_loaded} <= 2'h3;
		@(posedge i_core_clk);
		i_eeprom_loaded <= 1'b0;
		for (int r = 0; r < 2; r++) begin
			wr(LGPC_CFG_OFFS, 32'h0);
			{i_usb_reset, i_lite_soft_reset} <= r ? 2'h1 : 2'h2;
			@(posedge i_core_clk);
			{i_usb_reset, i_lite_soft_reset} <= 2'h0;
			rd(LGPC_CFG_OFFS, 32'h8000_0000);
		end
		for (int s = 0; s < 2; s++) begin
			wr(LGPC_CFG_OFFS, {s[0], 31'h0});
			repeat (4) begin
				i_link <= 4'($random(seed));
				repeat (3) @(posedge i_core_clk);
				pv = {~i_link.speed_100, ~(i_link.link_up & (s[0] | ~i_link.activity)), ~i_link.activity};
				chk({29'h0, leds}, {29'h0, pv});
			end
		end
		// Code 1 puts the LED roles on pins 8 and 9 (select is 0 here); codes 2 and 3 mirror MII signals.
		for (int c = 1; c < 4; c++) begin
			wr(LGPC_CFG_OFFS, 32'h770 | (c << 24) | (c << 20) | (c << 16));
			repeat (4) begin
				{i_mii, i_link} <= 10'($random(seed));
				repeat (3) @(posedge i_core_clk);
				if (c == 1)
					pv = {i_mii.rxd0, ~(i_link.link_up & ~i_link.activity), ~i_link.speed_100};
				else
					pv = c[0] ? {i_mii.rxd3, i_mii.phy_reset_low, i_mii.crs} : {i_mii.rxd0, i_mii.rxd1, i_mii.rxd2};
				chk({29'h0, o_pin_out}, {29'h0, pv});
				chk({29'h0, o_pin_oe}, 32'h7);
			end
		end
		report_and_stop();
	end
endmodule // lgpc_top_tb
`default_nettype wire
